// *** core/flash_pd_cfg.svh ***
// Constants for the flash power-down and pause control block.
// Assumes a 25 MHz system clock sampling all serial pins.
`ifndef FLASH_PD_CFG_SVH
`define FLASH_PD_CFG_SVH
`define OPC_RESUME          8'hab
`define OPC_POWERDOWN       8'hb9
`define CLK_MHZ             25
`define RESUME_LATENCY_US   30
`define RESUME_CYCLES       (`RESUME_LATENCY_US * `CLK_MHZ)
// Pin-to-decision lag, rounded up; taken off the latency loads so limits hold from the pin
`define SYNC_LAG_CYCLES     4
`define ENTRY_LATENCY_US    3
`define ENTRY_CYCLES        (`ENTRY_LATENCY_US * `CLK_MHZ)
`define BITCNT_W            3
`define LAT_W               10
`endif

// *** core/flash_pd_ctrl.sv ***
// Serial control for power-down, resume and pause of a SPI flash.
// Assumes pins come straight from the host; clk much faster than sck.
// How it works
// - In power-down only resume opcode acts
// - Whole bytes after resume opcode are ignored
// - Valid resume then deselect reaches standby
// - Short or misaligned resume stays powered down
// - Pause suspends traffic, clock keeps running
// - Pause never stalls self-timed operations
// - Pause only while chip selected
// - Pause entry waits for clock low
// - Pause holds while pin and select asserted
// - Paused: output released, clock and data ignored
// - Write-protect still followed while paused
// - Pause exit waits for clock low
// - Deselect while paused aborts, clears latch
// - Resume latency at most thirty microseconds
// - Power-down opcode then deselect enters it unless self-timed busy
`timescale 1ns/100ps
`default_nettype none
`include "flash_pd_cfg.svh"
module flash_pd_ctrl (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  cs_n,
  input  wire logic  sck,
  input  wire logic  din,
  input  wire logic  pause_n,
  input  wire logic  wp_n,
  input  wire logic  write_enable_set,
  input  wire logic  selftimed_busy,
  output logic       dout,
  output logic       dout_oe,
  output logic       write_enable_latch,
  output logic       wp_active,
  output logic       powered_down,
  output logic       standby,
  output logic       paused,
  output logic       cmd_abort
);
  flash_pd_pkg::pins_type          raw_pins;
  flash_pd_pkg::pins_type          pins;
  flash_pd_pkg::power_state_type   state_r;
  flash_pd_pkg::power_state_type   state_nxt;
  logic                            sck_d_r;
  logic                            cs_d_r;
  logic [`BITCNT_W-1:0]            bitcnt_r;
  logic                            byte_seen_r;
  logic [7:0]                      shift_r;
  logic [7:0]                      opcode_r;
  logic                            pause_r;
  logic [`LAT_W-1:0]               lat_r;
  logic                            wel_r;
  logic                            abort_r;

  assign raw_pins = '{cs_active: ~cs_n, sck: sck, din: din, pause_active: ~pause_n, wp_active: ~wp_n};

  pin_sync u_sync (
    .clk     (clk),
    .reset   (reset),
    .pins_in (raw_pins),
    .pins_out(pins)
  );

  // Edge finders on the synchronised pins; one flop of history each
  function automatic logic edge_up(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction
  function automatic logic edge_down(input logic now_v, input logic was_v);
    return ~now_v & was_v;
  endfunction

  wire sck_rise  = edge_up(pins.sck, sck_d_r);
  wire sck_fall  = edge_down(pins.sck, sck_d_r);
  wire cs_rise   = edge_up(pins.cs_active, cs_d_r);
  wire cs_fall   = edge_down(pins.cs_active, cs_d_r);
  wire sck_low   = ~pins.sck;
  // Pause changes only in clock low phase or when deselected; a high-phase change lands at the fall
  wire pause_nxt = pins.cs_active & pins.pause_active;
  wire pause_upd = ~pins.cs_active | sck_low;
  // Shift only when selected and not paused
  wire shift_en  = sck_rise & pins.cs_active & ~pause_r;
  wire [7:0] shift_nxt = {shift_r[6:0], pins.din};
  wire byte_done = shift_en & (bitcnt_r == 3'h7);
  wire aligned   = (bitcnt_r == 3'h0) & byte_seen_r;
  wire resume_ok = cs_fall & aligned & (opcode_r == `OPC_RESUME);
  wire pd_ok     = cs_fall & aligned & (opcode_r == `OPC_POWERDOWN) & ~selftimed_busy;
  wire pause_abort = cs_fall & pause_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      flash_pd_pkg::ST_STANDBY:   if (pd_ok && !pause_abort) state_nxt = flash_pd_pkg::ST_ENTERING;
      flash_pd_pkg::ST_ENTERING:  if (lat_r == '0) state_nxt = flash_pd_pkg::ST_POWERDOWN;
      // Other opcodes fall through as if never sent
      flash_pd_pkg::ST_POWERDOWN: if (resume_ok && !pause_abort) state_nxt = flash_pd_pkg::ST_RESUMING;
      flash_pd_pkg::ST_RESUMING:  if (lat_r == '0) state_nxt = flash_pd_pkg::ST_STANDBY;
      default:                    state_nxt = flash_pd_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b0;
      pause_r <= 1'b0;
    end else begin
      sck_d_r <= pins.sck;
      cs_d_r  <= pins.cs_active;
      if (pause_upd) pause_r <= pause_nxt;
    end
  end

  // Opcode is the first byte only; later bytes leave it alone
  always_ff @(posedge clk) begin
    if (reset || cs_rise) begin
      bitcnt_r    <= '0;
      byte_seen_r <= 1'b0;
      shift_r     <= '0;
      opcode_r    <= '0;
    end else if (shift_en) begin
      bitcnt_r <= bitcnt_r + 3'h1;
      shift_r  <= shift_nxt;
      if (byte_done) begin
        byte_seen_r <= 1'b1;
        if (!byte_seen_r) opcode_r <= shift_nxt;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= flash_pd_pkg::ST_STANDBY;
      lat_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r != state_nxt && state_nxt == flash_pd_pkg::ST_RESUMING)
        lat_r <= `LAT_W'(`RESUME_CYCLES - `SYNC_LAG_CYCLES - 1);
      else if (state_r != state_nxt && state_nxt == flash_pd_pkg::ST_ENTERING)
        lat_r <= `LAT_W'(`ENTRY_CYCLES - `SYNC_LAG_CYCLES - 1);
      else if (lat_r != '0)
        lat_r <= lat_r - `LAT_W'(1);
    end
  end

  // Latch is cleared by an aborted paused frame; set request loses to abort
  always_ff @(posedge clk) begin
    if (reset) begin
      wel_r   <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      abort_r <= pause_abort;
      if (pause_abort) wel_r <= 1'b0;
      else if (write_enable_set && state_r == flash_pd_pkg::ST_STANDBY) wel_r <= 1'b1;
    end
  end

  // Self-timed work is outside; busy never consults pause
  assign dout               = 1'b0;
  assign dout_oe            = 1'b0;
  assign write_enable_latch = wel_r;
  assign wp_active          = pins.wp_active;
  assign powered_down       = (state_r == flash_pd_pkg::ST_POWERDOWN);
  assign standby            = (state_r == flash_pd_pkg::ST_STANDBY);
  assign paused             = pause_r;
  assign cmd_abort          = abort_r;

  // Latency windows end exactly where the counters run out
  sequence seq_resume_done;
    ##[0:746] standby;
  endsequence
  sequence seq_entry_done;
    ##[0:71] powered_down;
  endsequence
  sequence seq_abort_seen;
    cmd_abort && !write_enable_latch;
  endsequence

  AST_RESUME_BOUND: assert property (@(posedge clk) disable iff (reset)
    (state_r == flash_pd_pkg::ST_RESUMING) |-> seq_resume_done)
    else $error("resume took too long");
  AST_ENTRY_BOUND: assert property (@(posedge clk) disable iff (reset)
    (state_r == flash_pd_pkg::ST_ENTERING) |-> seq_entry_done)
    else $error("power-down entry took too long");
  AST_ONLY_RESUME: assert property (@(posedge clk) disable iff (reset)
    ($past(powered_down) && !powered_down) |-> state_r == flash_pd_pkg::ST_RESUMING)
    else $error("power-down left without resume");
  AST_DPD_NO_WEL: assert property (@(posedge clk) disable iff (reset)
    (powered_down && !write_enable_latch) |=> !write_enable_latch)
    else $error("latch set in power-down");
  AST_RESUME_START: assert property (@(posedge clk) disable iff (reset)
    (resume_ok && powered_down && !pause_abort) |=> state_r == flash_pd_pkg::ST_RESUMING)
    else $error("valid resume ignored");
  AST_OPCODE_HELD: assert property (@(posedge clk) disable iff (reset)
    (byte_seen_r && !cs_rise) |=> $stable(opcode_r))
    else $error("later byte overwrote opcode");
  AST_MISALIGNED: assert property (@(posedge clk) disable iff (reset)
    (powered_down && cs_fall && !aligned) |=> powered_down)
    else $error("misaligned frame left power-down");
  AST_PAUSE_CS: assert property (@(posedge clk) disable iff (reset)
    (!pins.cs_active) |=> !paused)
    else $error("paused while deselected");
  AST_PAUSE_HIGH: assert property (@(posedge clk) disable iff (reset)
    (pins.sck && pins.cs_active && !paused) |=> !paused)
    else $error("pause entered in clock high phase");
  AST_NO_SHIFT: assert property (@(posedge clk) disable iff (reset)
    (paused && !cs_rise) |=> $stable(bitcnt_r))
    else $error("shift while paused");
  AST_WEL_CLEAR: assert property (@(posedge clk) disable iff (reset)
    pause_abort |=> seq_abort_seen)
    else $error("latch not cleared");
  AST_ABORT_PULSE: assert property (@(posedge clk) disable iff (reset)
    cmd_abort |=> !cmd_abort)
    else $error("abort pulse too long");
  AST_PAUSE_FALL: assert property (@(posedge clk) disable iff (reset)
    (sck_fall && pins.cs_active && pins.pause_active) |=> paused)
    else $error("pause not taken at clock fall");
  AST_PAUSE_HOLD: assert property (@(posedge clk) disable iff (reset)
    (paused && pins.cs_active && pins.pause_active) |=> paused)
    else $error("pause dropped while pin and select held");
  AST_EXIT_LOW: assert property (@(posedge clk) disable iff (reset)
    (paused && pins.sck && pins.cs_active) |=> paused)
    else $error("pause left in clock high phase");
endmodule // flash_pd_ctrl
`default_nettype wire

// *** core/flash_pd_pkg.sv ***
// Types for the flash power-down and pause control block.
// Assumes the constants header is included alongside.
package flash_pd_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_POWERDOWN,
    ST_RESUMING,
    ST_ENTERING
  } power_state_type;

  typedef struct packed {
    logic cs_active;
    logic sck;
    logic din;
    logic pause_active;
    logic wp_active;
  } pins_type;
endpackage

// *** core/pin_sync.sv ***
// Two-flop synchroniser bank for the serial pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire flash_pd_pkg::pins_type   pins_in,
  output var  flash_pd_pkg::pins_type   pins_out
);
  flash_pd_pkg::pins_type stage1_r;

  // Idle values: deselected, not paused
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_r <= '0;
      pins_out <= '0;
    end else begin
      stage1_r <= pins_in;
      pins_out <= stage1_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

// *** tb/spi_flash_resume_and_hold_tb_top.sv ***
// Bench for the flash power-down and pause control.
// Assumes the host model on the serial pins.
`timescale 1ns/100ps
`default_nettype none
module spi_flash_resume_and_hold_tb_top;
  logic clk, reset, write_enable_set, selftimed_busy;
  logic cs_n, sck, din, pause_n, wp_n;
  logic dout, dout_oe, write_enable_latch, wp_active, powered_down, standby, paused, cmd_abort;
  logic [2:0] watch;
  int         err_count = 0;
  int         tests_run = 0;
  assign watch = {cmd_abort, standby, powered_down};
  spi_host_model host_u (.clk(clk), .cs_n(cs_n), .sck(sck), .din(din), .pause_n(pause_n), .wp_n(wp_n));
  flash_pd_ctrl dut_u (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .din(din), .pause_n(pause_n),
    .wp_n(wp_n), .write_enable_set(write_enable_set), .selftimed_busy(selftimed_busy), .dout(dout),
    .dout_oe(dout_oe), .write_enable_latch(write_enable_latch), .wp_active(wp_active),
    .powered_down(powered_down), .standby(standby), .paused(paused), .cmd_abort(cmd_abort));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // Bounded wait for one watched flag to go high
  task automatic wait_for(input int sel, input int bound);
    int n;
    n = 0;
    while (watch[sel] !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    chk(watch[sel], 1'b1);
    if (watch[sel] !== 1'b1) close_out();
  endtask
  task automatic pause_deselected();
    host_u.set_pins(1'b0, 1'b1);
    repeat (8) @(posedge clk);
    chk(paused, 1'b0);
    host_u.set_pins(1'b1, 1'b1);
  endtask
  task automatic busy_powerdown();
    selftimed_busy <= 1'b1;
    host_u.frame(16'h00b9, 8);
    repeat (100) @(posedge clk);
    chk(standby, 1'b1);
    selftimed_busy <= 1'b0;
  endtask
  task automatic powerdown_resume();
    host_u.frame(16'h00b9, 8);
    wait_for(0, 100);
    host_u.frame(16'h009f, 8);
    chk(powered_down, 1'b1);
    host_u.frame(16'h0055, 7);
    chk(powered_down, 1'b1);
    host_u.frame(16'h0abc, 12);
    chk(powered_down, 1'b1);
    host_u.frame(16'habff, 16);
    // 750 cycles from deselect, less the 8 that stop spends after it
    wait_for(1, 742);
    chk(powered_down, 1'b0);
  endtask
  task automatic pause_high_phase();
    host_u.start();
    host_u.sck_level(1'b1);
    host_u.set_pins(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk(paused, 1'b0);
    host_u.sck_level(1'b0);
    chk(paused, 1'b1);
    host_u.sck_level(1'b1);
    host_u.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge clk);
    chk(paused, 1'b1);
    host_u.sck_level(1'b0);
    chk(paused, 1'b0);
    host_u.stop();
  endtask
  task automatic pause_abort();
    write_enable_set <= 1'b1;
    @(posedge clk);
    write_enable_set <= 1'b0;
    repeat (2) @(posedge clk);
    chk(write_enable_latch, 1'b1);
    host_u.start();
    host_u.bits(16'h0003, 3);
    host_u.set_pins(1'b0, 1'b1);
    host_u.bits(16'h0005, 3);
    chk(paused, 1'b1);
    chk(dout_oe, 1'b0);
    chk(dout, 1'b0);
    host_u.set_pins(1'b0, 1'b0);
    chk(wp_active, 1'b1);
    host_u.set_pins(1'b1, 1'b0);
    chk(paused, 1'b0);
    host_u.set_pins(1'b0, 1'b1);
    fork
      host_u.stop();
      wait_for(2, 20);
    join
    chk(write_enable_latch, 1'b0);
    host_u.set_pins(1'b1, 1'b1);
  endtask
  initial begin
    reset = 1'b1;
    write_enable_set = 1'b0;
    selftimed_busy = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    pause_deselected();
    busy_powerdown();
    powerdown_resume();
    pause_high_phase();
    pause_abort();
    close_out();
  end
endmodule // spi_flash_resume_and_hold_tb_top
`default_nettype wire

// *** tb/spi_host_model.sv ***
// Host controller model driving the serial pins.
// Assumes the bench clock; sck idles low outside frames.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      din,
  output logic      pause_n,
  output logic      wp_n
);
  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    din     = 1'b0;
    pause_n = 1'b1;
    wp_n    = 1'b1;
  end
  task automatic start();
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // MSB first, 4 clk per phase gives 320 ns
  task automatic bits(input logic [15:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      din <= d[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
  task automatic stop();
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    din  <= ~din; // Released line shows no stale bit
    repeat (8) @(posedge clk);
  endtask
  task automatic frame(input logic [15:0] d, input int n);
    start();
    bits(d, n);
    stop();
  endtask
  // Pins take 4 clk to settle inside
  task automatic set_pins(input logic p, input logic w);
    pause_n <= p;
    wp_n    <= w;
    repeat (4) @(posedge clk);
  endtask
  // One half period of sck at a chosen level, mid-frame
  task automatic sck_level(input logic s);
    sck <= s;
    repeat (4) @(posedge clk);
  endtask
endmodule // spi_host_model
`default_nettype wire
